// *** par_pkg.sv ***
// package: constants and types for the process alarm and key router
package par_pkg;

	localparam int NUM_ALARMS  = 6;
	localparam int NUM_INPUTS  = 8;
	localparam int VAL_W       = 16;
	localparam int SEL_W       = 3;
	localparam int CODE_W      = 32;
	localparam int NUM_KEYS    = 4;
	localparam int NUM_EXT     = 6;
	localparam int DIGITS      = 4;
	localparam int CHAR_W      = 8;

	// timing
	localparam int CLK_HZ          = 50_000_000;
	localparam int CODE_TMO_S      = 10;
	localparam int MENU_TMO_S      = 60;
	localparam int FLASH_HALF_MS   = 500;
	localparam int CODE_TMO_CYC    = CODE_TMO_S * CLK_HZ;
	localparam longint MENU_TMO_CYC = longint'(MENU_TMO_S) * longint'(CLK_HZ);
	localparam int FLASH_HALF_CYC  = FLASH_HALF_MS * (CLK_HZ / 1000);
	localparam int TMR_W           = 32;

	// register map (word addresses on the plain port)
	localparam int ADDR_W = 6;
	localparam logic [ADDR_W-1:0] REG_GLOBAL  = 6'h00;
	localparam logic [ADDR_W-1:0] REG_MCODE   = 6'h01;
	localparam logic [ADDR_W-1:0] REG_QCODE   = 6'h02;
	localparam logic [ADDR_W-1:0] REG_DISP    = 6'h03;
	localparam logic [ADDR_W-1:0] REG_CMD     = 6'h04;
	localparam logic [ADDR_W-1:0] REG_STATUS  = 6'h05;
	localparam logic [ADDR_W-1:0] REG_SUMMARY = 6'h06;
	localparam logic [ADDR_W-1:0] REG_ACFG0   = 6'h10;
	localparam logic [ADDR_W-1:0] REG_ALO0    = 6'h18;
	localparam logic [ADDR_W-1:0] REG_AHI0    = 6'h20;
	localparam logic [ADDR_W-1:0] REG_AHYS0   = 6'h28;

	// global register fields
	localparam int G_GOOD_ONLY = 0;
	localparam int G_QUICK_EN  = 1;
	localparam int G_STATTXT   = 2;
	localparam int G_KEYSRC_LO = 3;
	localparam int G_LAST_LO   = 5;
	// alarm config fields
	localparam int A_SEL_LO  = 0;
	localparam int A_LO_EN   = 3;
	localparam int A_HI_EN   = 4;
	localparam int A_HYS_EN  = 5;
	localparam int A_NC      = 6;
	// command bits
	localparam int C_DISP_DEF = 0;
	localparam int C_BUS_DEF  = 1;

	// factory values
	localparam logic [7:0]  DEF_BRIGHT   = 8'h64;
	localparam logic [7:0]  DEF_CONTRAST = 8'h32;
	localparam logic [31:0] CODE_ZERO    = 32'h30303030;
	localparam logic [SEL_W-1:0] DEF_LAST = 3'h7;

	typedef enum logic [1:0] {
		PAR_KEYS_INT  = 2'b00,
		PAR_KEYS_EXT  = 2'b01,
		PAR_KEYS_BOTH = 2'b10
	} par_keysrc_t;

	typedef enum logic [2:0] {
		PAR_ST_OPER  = 3'b000,
		PAR_ST_CODE  = 3'b001,
		PAR_ST_MENU  = 3'b010,
		PAR_ST_QUICK = 3'b011,
		PAR_ST_EDIT  = 3'b100
	} par_state_t;

	// key bits: 0 program, 1 enter, 2 down, 3 up
	localparam int K_P = 0;
	localparam int K_E = 1;
	localparam int K_DN = 2;
	localparam int K_UP = 3;

	typedef struct packed {
		// high bit first, so the word matches the register field positions
		logic             nc;
		logic             hys_en;
		logic             hi_en;
		logic             lo_en;
		logic [SEL_W-1:0] sel;
	} par_acfg_t;

	typedef struct packed {
		logic [SEL_W-1:0] last;
		par_keysrc_t      keysrc;
		logic             stat_txt;
		logic             quick_en;
		logic             good_only;
	} par_glob_t;

endpackage

// *** par_router.sv ***
// process alarm evaluation, code gating and key routing
// Operation
// - six alarms, each picks one of eight inputs
// - trip on low, high or both
// - selectable open or closed rest polarity
// - outputs open when unpowered
// - active alarm flashes linked variable field
// - not-good variables shown inverted
// - global good-data-only alarm activation
// - low, high, hysteresis enables plus setpoints
// - summary view shows config, read only
// - quick path adjusts brightness and contrast only
// - quick code match, zeros bypass prompt
// - menu code match, zeros bypass prompt
// - status text shows good or bad
// - last input caps scrolling range
// - four of the six external keys (bits 3:0) can take over
// - key routing per key source setting
// - display defaults overwrite all display settings
// - bus defaults restore and drop communication
// - timeout ten seconds code, sixty menu
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
module par_router
	import par_pkg::*;
#(
	parameter int CODE_TMO = CODE_TMO_CYC,
	parameter longint MENU_TMO = MENU_TMO_CYC,
	parameter int FLASH_HALF = FLASH_HALF_CYC
)(
	input  wire logic                          i_clk,
	input  wire logic                          i_reset_n,
	input  wire logic [ADDR_W-1:0]             i_addr,
	input  wire logic [31:0]                   i_wdata,
	input  wire logic                          i_wr,
	input  wire logic                          i_rd,
	output logic      [31:0]                   o_rdata,
	input  wire logic [NUM_INPUTS*VAL_W-1:0]   i_pv,
	input  wire logic [NUM_INPUTS-1:0]         i_pv_good,
	input  wire logic                          i_pv_upd,
	input  wire logic                          i_powered,
	input  wire logic [NUM_KEYS-1:0]           i_front_keys,
	input  wire logic [NUM_EXT-1:0]            i_ext_keys,
	input  wire logic [CHAR_W-1:0]             i_char,
	output logic      [NUM_ALARMS-1:0]         o_relay_closed,
	output logic      [NUM_INPUTS-1:0]         o_pv_inverse,
	output logic      [NUM_INPUTS-1:0]         o_stat_good_txt,
	output logic      [SEL_W-1:0]              o_cur_input,
	output logic      [2:0]                    o_mode,
	output logic      [7:0]                    o_bright,
	output logic      [7:0]                    o_contrast,
	output logic                               o_bus_reset
);

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	logic [NUM_KEYS-1:0] fk_s1_ff, fk_s2_ff;
	logic [NUM_EXT-1:0]  ek_s1_ff, ek_s2_ff;
	logic                pw_s1_ff, pw_s2_ff;
	always_ff @(posedge i_clk)
	begin
		fk_s1_ff <= i_front_keys;
		fk_s2_ff <= fk_s1_ff;
		ek_s1_ff <= i_ext_keys;
		ek_s2_ff <= ek_s1_ff;
		pw_s1_ff <= i_powered;
		pw_s2_ff <= pw_s1_ff;
	end

	// ------------------------------------------------------------
	// configuration state
	// ------------------------------------------------------------
	par_glob_t                     glob_ff, nxt_glob;
	logic [CODE_W-1:0]             mcode_ff, nxt_mcode, qcode_ff, nxt_qcode;
	logic [7:0]                    bright_ff, nxt_bright, contr_ff, nxt_contr;
	par_acfg_t [NUM_ALARMS-1:0]    acfg_ff, nxt_acfg;
	logic [NUM_ALARMS-1:0][VAL_W-1:0] lo_ff, nxt_lo, hi_ff, nxt_hi, hys_ff, nxt_hys;
	logic [NUM_ALARMS-1:0][VAL_W-1:0] stage_ff, nxt_stage;
	logic                          busrst_ff, nxt_busrst;
	par_state_t                    st_ff, nxt_st;
	logic [TMR_W-1:0]              tmr_ff, nxt_tmr;
	logic [CODE_W-1:0]             entry_ff, nxt_entry;
	logic [1:0]                    dig_ff, nxt_dig;
	logic                          quick_tgt_ff, nxt_quick_tgt;
	logic [SEL_W-1:0]              cur_ff, nxt_cur;
	logic [NUM_KEYS-1:0]           kprev_ff;
	logic [NUM_ALARMS-1:0]         trip_ff, nxt_trip;
	logic [TMR_W-1:0]              fl_cnt_ff, nxt_fl_cnt;
	logic                          fl_ph_ff, nxt_fl_ph;
	logic [31:0]                   rdata_ff, nxt_rdata;

	// ------------------------------------------------------------
	// key routing
	// ------------------------------------------------------------
	logic [NUM_KEYS-1:0] scroll_keys, menu_keys, quick_keys, kedge;
	logic                combo_menu, combo_quick, any_key;
	always_comb
	begin
		unique case (glob_ff.keysrc)
			PAR_KEYS_EXT:
			begin
				scroll_keys = ek_s2_ff[NUM_KEYS-1:0];
				menu_keys   = ek_s2_ff[NUM_KEYS-1:0] | fk_s2_ff;
				quick_keys  = ek_s2_ff[NUM_KEYS-1:0];
			end
			PAR_KEYS_BOTH:
			begin
				scroll_keys = ek_s2_ff[NUM_KEYS-1:0] | fk_s2_ff;
				menu_keys   = scroll_keys;
				quick_keys  = scroll_keys;
			end
			default:
			begin
				scroll_keys = fk_s2_ff;
				menu_keys   = fk_s2_ff;
				quick_keys  = fk_s2_ff;
			end
		endcase
		combo_menu  = menu_keys[K_P] & menu_keys[K_E] & ~kprev_ff[K_E];
		combo_quick = quick_keys[K_P] & quick_keys[K_UP] & ~kprev_ff[K_UP];
		kedge       = scroll_keys & ~kprev_ff;
		any_key     = |(menu_keys & ~kprev_ff);
	end

	// ------------------------------------------------------------
	// menu state machine and register writes
	// ------------------------------------------------------------
	logic [CHAR_W-1:0] ch_next;
	int                aidx;
	always_comb
	begin
		nxt_glob      = glob_ff;
		nxt_mcode     = mcode_ff;
		nxt_qcode     = qcode_ff;
		nxt_bright    = bright_ff;
		nxt_contr     = contr_ff;
		nxt_acfg      = acfg_ff;
		nxt_lo        = lo_ff;
		nxt_hi        = hi_ff;
		nxt_hys       = hys_ff;
		nxt_stage     = stage_ff;
		nxt_busrst    = 1'b0;
		nxt_st        = st_ff;
		nxt_tmr       = tmr_ff;
		nxt_entry     = entry_ff;
		nxt_dig       = dig_ff;
		nxt_quick_tgt = quick_tgt_ff;
		nxt_cur       = cur_ff;
		ch_next       = i_char;
		aidx          = int'(i_addr[2:0]);
		if (st_ff != PAR_ST_OPER)
			nxt_tmr = (any_key) ? '0 : tmr_ff + 1'b1;
		unique case (st_ff)
			PAR_ST_OPER:
			begin
				nxt_tmr = '0;
				if (combo_menu)
				begin
					nxt_quick_tgt = 1'b0;
					nxt_dig       = '0;
					nxt_entry     = CODE_ZERO;
					nxt_st = (mcode_ff == CODE_ZERO) ? PAR_ST_MENU : PAR_ST_CODE;
				end
				else if (combo_quick && glob_ff.quick_en)
				begin
					nxt_quick_tgt = 1'b1;
					nxt_dig       = '0;
					nxt_entry     = CODE_ZERO;
					nxt_st = (qcode_ff == CODE_ZERO) ? PAR_ST_QUICK : PAR_ST_CODE;
				end
				else if (kedge[K_UP])
					nxt_cur = (cur_ff >= glob_ff.last) ? '0 : cur_ff + 1'b1;
				else if (kedge[K_DN])
					nxt_cur = (cur_ff == '0 || cur_ff > glob_ff.last) ? glob_ff.last
						: cur_ff - 1'b1;
			end
			PAR_ST_CODE:
			begin
				if (kedge[K_UP] || kedge[K_DN])
					nxt_entry[(DIGITS-1-int'(dig_ff))*CHAR_W +: CHAR_W] = ch_next;
				else if (kedge[K_P])
					nxt_dig = dig_ff + 1'b1;
				else if (kedge[K_E])
				begin
					if (quick_tgt_ff)
						nxt_st = (entry_ff == qcode_ff) ? PAR_ST_QUICK : PAR_ST_OPER;
					else
						nxt_st = (entry_ff == mcode_ff) ? PAR_ST_MENU : PAR_ST_OPER;
				end
				if (tmr_ff >= TMR_W'(CODE_TMO - 1))
					nxt_st = PAR_ST_OPER;
			end
			PAR_ST_QUICK:
			begin
				// only brightness and contrast are reachable here
				if (kedge[K_UP])
					nxt_bright = bright_ff + 1'b1;
				else if (kedge[K_DN])
					nxt_bright = bright_ff - 1'b1;
				else if (kedge[K_P])
					nxt_st = PAR_ST_EDIT;
				else if (kedge[K_E])
					nxt_st = PAR_ST_OPER;
				if (tmr_ff >= TMR_W'(MENU_TMO - 1))
					nxt_st = PAR_ST_OPER;
			end
			PAR_ST_EDIT:
			begin
				if (kedge[K_UP])
					nxt_contr = contr_ff + 1'b1;
				else if (kedge[K_DN])
					nxt_contr = contr_ff - 1'b1;
				else if (kedge[K_E])
					nxt_st = PAR_ST_OPER;
				if (tmr_ff >= TMR_W'(MENU_TMO - 1))
					nxt_st = PAR_ST_OPER;
			end
			PAR_ST_MENU:
			begin
				if (kedge[K_E])
					nxt_st = PAR_ST_OPER;
				if (tmr_ff >= TMR_W'(MENU_TMO - 1))
					nxt_st = PAR_ST_OPER;
			end
			default: nxt_st = PAR_ST_OPER;
		endcase
		// configuration writes are accepted only inside the full menu
		if (i_wr && st_ff == PAR_ST_MENU)
		begin
			if (i_addr == REG_GLOBAL)
			begin
				nxt_glob.good_only = i_wdata[G_GOOD_ONLY];
				nxt_glob.quick_en  = i_wdata[G_QUICK_EN];
				nxt_glob.stat_txt  = i_wdata[G_STATTXT];
				nxt_glob.keysrc    = par_keysrc_t'(i_wdata[G_KEYSRC_LO +: 2]);
				nxt_glob.last      = i_wdata[G_LAST_LO +: SEL_W];
			end
			else if (i_addr == REG_MCODE)
				nxt_mcode = i_wdata;
			else if (i_addr == REG_QCODE)
				nxt_qcode = i_wdata;
			else if (i_addr == REG_DISP)
			begin
				nxt_bright = i_wdata[7:0];
				nxt_contr  = i_wdata[15:8];
			end
			else if (i_addr == REG_CMD)
			begin
				if (i_wdata[C_DISP_DEF])
				begin
					nxt_bright = DEF_BRIGHT;
					nxt_contr  = DEF_CONTRAST;
					nxt_mcode  = CODE_ZERO;
					nxt_qcode  = CODE_ZERO;
					nxt_glob   = '{DEF_LAST, PAR_KEYS_BOTH, 1'b1, 1'b1, 1'b1};
					nxt_acfg   = '{default: '0};
				end
				nxt_busrst = i_wdata[C_BUS_DEF];
			end
			else if (i_addr >= REG_ACFG0 && aidx < NUM_ALARMS)
			begin
				if (i_addr[5:3] == REG_ACFG0[5:3])
					nxt_acfg[aidx] = i_wdata[A_NC:0];
				else if (i_addr[5:3] == REG_ALO0[5:3])
					nxt_stage[aidx] = i_wdata[VAL_W-1:0];
				else if (i_addr[5:3] == REG_AHI0[5:3])
					nxt_stage[aidx] = i_wdata[VAL_W-1:0];
				else if (i_addr[5:3] == REG_AHYS0[5:3])
					nxt_hys[aidx] = i_wdata[VAL_W-1:0];
				// commit on the setpoint's upper half-word strobe
				if (i_wdata[31] && i_addr[5:3] == REG_ALO0[5:3])
					nxt_lo[aidx] = stage_ff[aidx];
				if (i_wdata[31] && i_addr[5:3] == REG_AHI0[5:3])
					nxt_hi[aidx] = stage_ff[aidx];
			end
		end
	end

	// ------------------------------------------------------------
	// alarm evaluation and flashing
	// ------------------------------------------------------------
	logic [VAL_W-1:0] pv_sel;
	logic             pv_ok, lo_c, hi_c, lo_clr, hi_clr;
	logic [VAL_W:0]   lo_band, hi_band;
	always_comb
	begin
		nxt_trip   = trip_ff;
		nxt_fl_cnt = (fl_cnt_ff >= TMR_W'(FLASH_HALF - 1)) ? '0 : fl_cnt_ff + 1'b1;
		nxt_fl_ph  = (fl_cnt_ff >= TMR_W'(FLASH_HALF - 1)) ? ~fl_ph_ff : fl_ph_ff;
		pv_sel = '0;
		pv_ok  = 1'b0;
		lo_c = 1'b0; hi_c = 1'b0; lo_clr = 1'b0; hi_clr = 1'b0;
		lo_band = '0; hi_band = '0;
		for (int a = 0; a < NUM_ALARMS; a++)
		begin
			pv_sel  = i_pv[acfg_ff[a].sel*VAL_W +: VAL_W];
			pv_ok   = i_pv_good[acfg_ff[a].sel] | ~glob_ff.good_only;
			lo_band = {1'b0, lo_ff[a]} + {1'b0, (acfg_ff[a].hys_en ? hys_ff[a] : VAL_W'(0))};
			hi_band = {1'b0, hi_ff[a]} - {1'b0, (acfg_ff[a].hys_en ? hys_ff[a] : VAL_W'(0))};
			lo_c    = acfg_ff[a].lo_en && pv_sel < lo_ff[a];
			hi_c    = acfg_ff[a].hi_en && pv_sel > hi_ff[a];
			lo_clr  = !acfg_ff[a].lo_en || {1'b0, pv_sel} >= lo_band;
			hi_clr  = !acfg_ff[a].hi_en || (!hi_band[VAL_W] && {1'b0, pv_sel} <= hi_band);
			if (i_pv_upd)
			begin
				if (!pv_ok)
					nxt_trip[a] = 1'b0;
				else if (lo_c || hi_c)
					nxt_trip[a] = 1'b1;
				else if (lo_clr && hi_clr)
					nxt_trip[a] = 1'b0;
			end
		end
	end

	// summary word: input selects, then low and high enables; polarity stays in the per-channel words
	logic [31:0] summ;
	always_comb
	begin
		summ = '0;
		for (int a = 0; a < NUM_ALARMS; a++)
		begin
			summ[a*SEL_W +: SEL_W]           = acfg_ff[a].sel;
			summ[NUM_ALARMS*SEL_W + a]       = acfg_ff[a].lo_en;
			summ[NUM_ALARMS*(SEL_W + 1) + a] = acfg_ff[a].hi_en;
		end
	end

	logic [NUM_INPUTS-1:0] flash_req;
	always_comb
	begin
		flash_req = '0;
		for (int a = 0; a < NUM_ALARMS; a++)
			if (trip_ff[a])
				flash_req[acfg_ff[a].sel] = 1'b1;
	end

	// ------------------------------------------------------------
	// read port: summary and status are read only
	// ------------------------------------------------------------
	always_comb
	begin
		nxt_rdata = '0;
		if (i_rd)
		begin
			if (i_addr == REG_GLOBAL)
				nxt_rdata = {24'h000000, glob_ff};
			else if (i_addr == REG_DISP)
				nxt_rdata = {16'h0000, contr_ff, bright_ff};
			else if (i_addr == REG_STATUS)
				nxt_rdata = {16'h0000, 2'h0, trip_ff, 5'h00, st_ff};
			else if (i_addr == REG_SUMMARY)
				nxt_rdata = summ;
			else if (i_addr[5:3] == REG_ACFG0[5:3] && aidx < NUM_ALARMS)
				nxt_rdata = {25'h0000000, acfg_ff[aidx]};
			else if (i_addr[5:3] == REG_ALO0[5:3] && aidx < NUM_ALARMS)
				nxt_rdata = {16'h0000, lo_ff[aidx]};
			else if (i_addr[5:3] == REG_AHI0[5:3] && aidx < NUM_ALARMS)
				nxt_rdata = {16'h0000, hi_ff[aidx]};
			else if (i_addr[5:3] == REG_AHYS0[5:3] && aidx < NUM_ALARMS)
				nxt_rdata = {16'h0000, hys_ff[aidx]};
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			glob_ff      <= '{DEF_LAST, PAR_KEYS_BOTH, 1'b1, 1'b1, 1'b1};
			mcode_ff     <= CODE_ZERO;
			qcode_ff     <= CODE_ZERO;
			bright_ff    <= DEF_BRIGHT;
			contr_ff     <= DEF_CONTRAST;
			acfg_ff      <= '{default: '0};
			lo_ff        <= '0;
			hi_ff        <= '0;
			hys_ff       <= '0;
			stage_ff     <= '0;
			busrst_ff    <= 1'b0;
			st_ff        <= PAR_ST_OPER;
			tmr_ff       <= '0;
			entry_ff     <= CODE_ZERO;
			dig_ff       <= '0;
			quick_tgt_ff <= 1'b0;
			cur_ff       <= '0;
			kprev_ff     <= '0;
			trip_ff      <= '0;
			fl_cnt_ff    <= '0;
			fl_ph_ff     <= 1'b0;
			rdata_ff     <= '0;
		end
		else
		begin
			glob_ff      <= nxt_glob;
			mcode_ff     <= nxt_mcode;
			qcode_ff     <= nxt_qcode;
			bright_ff    <= nxt_bright;
			contr_ff     <= nxt_contr;
			acfg_ff      <= nxt_acfg;
			lo_ff        <= nxt_lo;
			hi_ff        <= nxt_hi;
			hys_ff       <= nxt_hys;
			stage_ff     <= nxt_stage;
			busrst_ff    <= nxt_busrst;
			st_ff        <= nxt_st;
			tmr_ff       <= nxt_tmr;
			entry_ff     <= nxt_entry;
			dig_ff       <= nxt_dig;
			quick_tgt_ff <= nxt_quick_tgt;
			cur_ff       <= nxt_cur;
			kprev_ff     <= menu_keys;
			trip_ff      <= nxt_trip;
			fl_cnt_ff    <= nxt_fl_cnt;
			fl_ph_ff     <= nxt_fl_ph;
			rdata_ff     <= nxt_rdata;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	always_comb
	begin
		for (int a = 0; a < NUM_ALARMS; a++)
			o_relay_closed[a] = pw_s2_ff & (acfg_ff[a].nc ^ trip_ff[a]);
		o_pv_inverse    = ~i_pv_good ^ (flash_req & {NUM_INPUTS{fl_ph_ff}});
		o_stat_good_txt = glob_ff.stat_txt ? i_pv_good : '0;
	end
	assign o_rdata     = rdata_ff;
	assign o_cur_input = cur_ff;
	assign o_mode      = st_ff;
	assign o_bright    = bright_ff;
	assign o_contrast  = contr_ff;
	assign o_bus_reset = busrst_ff;

endmodule // par_router

// *** par_router_props.sv ***
// assertion checker for the process alarm and key router
`timescale 1ns/1ps
module par_router_props
	import par_pkg::*;
#(
	parameter longint MENU_TMO = MENU_TMO_CYC
)(
	input wire logic                  i_clk,
	input wire logic                  i_reset_n,
	input wire logic [ADDR_W-1:0]     i_addr,
	input wire logic [31:0]           i_wdata,
	input wire logic                  i_wr,
	input wire logic                  i_rd,
	input wire logic [31:0]           o_rdata,
	input wire logic [NUM_INPUTS-1:0] i_pv_good,
	input wire logic                  i_powered,
	input wire logic [NUM_KEYS-1:0]   i_front_keys,
	input wire logic [NUM_EXT-1:0]    i_ext_keys,
	input wire logic [NUM_ALARMS-1:0] o_relay_closed,
	input wire logic [NUM_INPUTS-1:0] o_stat_good_txt,
	input wire logic [2:0]            o_mode,
	input wire logic [7:0]            o_bright,
	input wire logic [7:0]            o_contrast,
	input wire logic                  o_bus_reset
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	logic [TMR_W-1:0] idle_ff;
	logic [TMR_W-1:0] nxt_idle;
	logic [9:0]       keys_ff;
	// cycles spent outside operating mode since any key moved
	always_comb nxt_idle = (o_mode == 3'h0 || keys_ff != {i_ext_keys, i_front_keys}) ? '0 : idle_ff + 1'b1;
	always_ff @(posedge i_clk)
	begin
		idle_ff <= i_reset_n ? nxt_idle : '0;
		keys_ff <= {i_ext_keys, i_front_keys};
	end
	unpowered_open_a: assert property (!i_powered ##1 !i_powered ##1 !i_powered |-> o_relay_closed == '0)
		else $error("relay closed while unpowered");
	rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == '0)
		else $error("read data outside read answer");
	bus_pulse_a: assert property (o_bus_reset |=> !o_bus_reset)
		else $error("bus reset longer than one cycle");
	bus_cause_a: assert property (o_bus_reset |-> $past(i_wr && i_addr == REG_CMD && i_wdata[C_BUS_DEF]))
		else $error("bus reset without command");
	disp_def_a: assert property (i_wr && i_addr == REG_CMD && i_wdata[C_DISP_DEF] && o_mode == 3'h2
		|=> o_bright == DEF_BRIGHT && o_contrast == DEF_CONTRAST)
		else $error("display defaults not restored");
	disp_write_a: assert property (i_wr && i_addr == REG_DISP && o_mode == 3'h2
		|=> o_bright == $past(i_wdata[7:0]) && o_contrast == $past(i_wdata[15:8]))
		else $error("display settings write lost");
	write_gate_a: assert property (i_wr && o_mode == 3'h0 |=> $stable(o_bright) && $stable(o_contrast))
		else $error("write acted outside menu");
	stat_txt_a: assert property (i_pv_good == $past(i_pv_good) && i_pv_good == $past(i_pv_good, 2)
		|-> (o_stat_good_txt & ~i_pv_good) == '0)
		else $error("good text on bad input");
	menu_tmo_a: assert property (idle_ff <= MENU_TMO + 8)
		else $error("menu did not time out");
endmodule // par_router_props

// *** par_host_model.sv ***
// fieldbus host model publishing process values to the router
`timescale 1ns/1ps
module par_host_model
	import par_pkg::*;
(
	input  wire logic                        i_clk,
	output logic      [NUM_INPUTS*VAL_W-1:0] o_pv,
	output logic      [NUM_INPUTS-1:0]       o_pv_good,
	output logic                             o_pv_upd
);
	initial
	begin
		o_pv = '0;
		o_pv_good = '1;
		o_pv_upd = 1'b0;
	end
	// values and status change together with one update pulse
	task automatic publish(input logic [NUM_INPUTS*VAL_W-1:0] vals, input logic [NUM_INPUTS-1:0] good);
		@(posedge i_clk);
		o_pv <= vals;
		o_pv_good <= good;
		o_pv_upd <= 1'b1;
		@(posedge i_clk);
		o_pv_upd <= 1'b0;
	endtask
endmodule // par_host_model

// *** par_router_tb_top.sv ***
// self-checking testbench for the process alarm and key router
`timescale 1ns/1ps
module par_router_tb_top import par_pkg::*;;
	localparam int MTMO = 600;
	logic [ADDR_W-1:0] i_addr;
	logic [31:0] i_wdata, o_rdata, v;
	logic i_clk, i_reset_n, i_wr, i_rd, i_powered, i_pv_upd, o_bus_reset, bus_seen;
	logic [NUM_INPUTS*VAL_W-1:0] i_pv, pv;
	logic [NUM_INPUTS-1:0] i_pv_good, o_pv_inverse, o_stat_good_txt;
	logic [NUM_KEYS-1:0] i_front_keys;
	logic [NUM_EXT-1:0] i_ext_keys;
	logic [CHAR_W-1:0] i_char;
	logic [NUM_ALARMS-1:0] o_relay_closed, nc, lo_en, hi_en;
	logic [SEL_W-1:0] o_cur_input, cur0, sel [NUM_ALARMS];
	logic [2:0] o_mode;
	logic [7:0] o_bright, o_contrast;
	logic [VAL_W-1:0] lo [NUM_ALARMS], hi [NUM_ALARMS];
	int seed = 80334, n_fail = 0, n_checks = 0;

	par_router #(.CODE_TMO(100), .MENU_TMO(MTMO), .FLASH_HALF(4)) par_router_inst (.*);
	par_host_model par_host_model_inst (.i_clk(i_clk), .o_pv(i_pv), .o_pv_good(i_pv_good), .o_pv_upd(i_pv_upd));

	initial
	begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	always @(posedge i_clk) if (o_bus_reset === 1'b1) bus_seen <= 1'b1;

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 v = o_rdata;
	endtask
	// stage then commit one setpoint
	task automatic setp(input logic [ADDR_W-1:0] a, input logic [VAL_W-1:0] d);
		wr(a, {16'h0, d});
		wr(a, 32'h8000_0000);
	endtask
	task automatic press(input logic [3:0] f, input logic [5:0] e);
		@(posedge i_clk);
		i_front_keys <= f;
		i_ext_keys <= e;
		tick(6);
		i_front_keys <= 4'h0;
		i_ext_keys <= 6'h0;
		tick(6);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	function automatic logic [NUM_ALARMS-1:0] exp_relay(input logic [7:0] good, input logic gonly);
		logic [VAL_W-1:0] x;
		logic t;
		exp_relay = '0;
		for (int a = 0; a < NUM_ALARMS; a++)
		begin
			x = pv[sel[a]*VAL_W +: VAL_W];
			t = (lo_en[a] && x < lo[a]) || (hi_en[a] && x > hi[a]);
			exp_relay[a] = nc[a] ^ (t && !(gonly && !good[sel[a]]));
		end
	endfunction

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		{i_reset_n, i_wr, i_rd, i_addr, i_wdata, i_char, i_front_keys, i_ext_keys, bus_seen} = '0;
		i_powered = 1'b1;
		tick(16);
		i_reset_n <= 1'b1;
		tick(2);
		chk("reset", {6'h0, 8'h32, 8'h64, 3'h0}, {o_relay_closed, o_contrast, o_bright, o_mode});
		press(4'h3, 6'h0);
		chk("menu", 3'h2, o_mode);
		wr(REG_GLOBAL, 32'h0000_00F7);
		for (int a = 0; a < NUM_ALARMS; a++)
		begin
			sel[a] = 3'($random(seed));
			{nc[a], lo_en[a], hi_en[a]} = 3'($random(seed));
			hi_en[a] = hi_en[a] | (a == 0);
			lo[a] = 16'($random(seed));
			hi[a] = 16'($random(seed));
			wr(REG_ACFG0 + 6'(a), {25'h0, nc[a], 1'b0, hi_en[a], lo_en[a], sel[a]});
			setp(REG_ALO0 + 6'(a), lo[a]);
			setp(REG_AHI0 + 6'(a), hi[a]);
		end
		for (int n = 0; n < 24; n++)
		begin
			for (int k = 0; k < NUM_INPUTS; k++) pv[k*VAL_W +: VAL_W] = 16'($random(seed));
			if (n == 0) pv[sel[0]*VAL_W +: VAL_W] = lo[0];
			if (n == 1) pv[sel[0]*VAL_W +: VAL_W] = hi[0];
			par_host_model_inst.publish(pv, 8'hFF);
			tick(3);
			chk("relay", exp_relay(8'hFF, 1'b1), o_relay_closed);
		end
		chk("stat_txt", 8'hFF, o_stat_good_txt);
		pv[sel[0]*VAL_W +: VAL_W] = 16'hFFFF;
		wr(REG_AHI0, 32'h0000_FFFE);
		par_host_model_inst.publish(pv, 8'hFF);
		tick(3);
		chk("staged", exp_relay(8'hFF, 1'b1), o_relay_closed);
		wr(REG_AHI0, 32'h8000_0000);
		hi[0] = 16'hFFFE;
		par_host_model_inst.publish(pv, 8'hFF);
		tick(3);
		chk("commit", exp_relay(8'hFF, 1'b1), o_relay_closed);
		par_host_model_inst.publish(pv, 8'h00);
		tick(3);
		chk("good_only", nc, o_relay_closed);
		chk("inverse", 8'hFF, o_pv_inverse);
		chk("bad_txt", 8'h00, o_stat_good_txt);
		wr(REG_GLOBAL, 32'h0000_00F6);
		par_host_model_inst.publish(pv, 8'h00);
		tick(3);
		chk("any_data", exp_relay(8'h00, 1'b0), o_relay_closed);
		i_powered <= 1'b0;
		tick(4);
		chk("unpowered", 6'h0, o_relay_closed);
		i_powered <= 1'b1;
		wr(REG_ACFG0, 32'h0000_0028);
		setp(REG_ALO0, 16'd100);
		wr(REG_AHYS0, 32'h0000_000A);
		foreach (lo[i]) pv[i*VAL_W +: VAL_W] = 16'h0;
		foreach (lo[i]) pv[(i+1)*VAL_W-1 -: VAL_W] = pv[i*VAL_W +: VAL_W];
		for (int s = 0; s < 3; s++)
		begin
			pv[VAL_W-1:0] = (s == 0) ? 16'd90 : (s == 1) ? 16'd109 : 16'd110;
			par_host_model_inst.publish(pv, 8'hFF);
			tick(3);
			chk("hysteresis", s != 2, o_relay_closed[0]);
			if (s == 0)
			begin
				v[0] = o_pv_inverse[0];
				tick(4);
				chk("flash", !v[0], o_pv_inverse[0]);
			end
		end
		wr(REG_DISP, 32'h0000_1234);
		tick(1);
		chk("disp", 16'h1234, {o_contrast, o_bright});
		wr(REG_CMD, 32'h0000_0001);
		tick(1);
		chk("disp_def", 16'h3264, {o_contrast, o_bright});
		wr(REG_CMD, 32'h0000_0002);
		tick(3);
		chk("bus_def", 1'b1, bus_seen);
		rd(REG_STATUS);
		chk("status", 3'h2, v[2:0]);
		rd(REG_SUMMARY);
		chk("summary_rd", 32'h0, v);
		wr(REG_SUMMARY, 32'hFFFF_FFFF);
		rd(REG_SUMMARY);
		chk("summary", 32'h0, v);
		rd(6'h3F);
		chk("unmapped", 32'h0, v);
		wr(REG_GLOBAL, 32'h0000_00EF);
		tick(MTMO + 20);
		chk("timeout", 3'h0, o_mode);
		wr(REG_DISP, 32'h0000_5555);
		tick(1);
		chk("locked", 16'h3264, {o_contrast, o_bright});
		cur0 = o_cur_input;
		press(4'h8, 6'h00);
		chk("front_scroll", cur0, o_cur_input);
		press(4'h0, 6'h08);
		chk("ext_scroll", 3'(cur0 + 1), o_cur_input);
		press(4'h3, 6'h00);
		chk("front_menu", 3'h2, o_mode);
		press(4'h0, 6'h02);
		chk("menu_exit", 3'h0, o_mode);
		press(4'h0, 6'h09);
		chk("quick", 3'h3, o_mode);
		press(4'h0, 6'h08);
		chk("quick_bright", 16'h3265, {o_contrast, o_bright});
		close_out();
	end
	initial
	begin
		#(20 * 20000);
		n_fail++;
		close_out();
	end
endmodule // par_router_tb_top

bind par_router par_router_props #(.MENU_TMO(MENU_TMO)) par_router_props_inst (.*);
